// >>> design/scs_corr_store.v
`timescale 1ns/1ns
`default_nettype none

// Per-channel correction storage, one array per data-set kind.
// No reset and no clear path: contents survive any reset of the block.
module scs_corr_store (
  input wire clk,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [1:0] wr_kind,
  input wire [15:0] wr_data,
  input wire [7:0] rd_addr,
  output wire [63:0] rd_data
);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_kind
      localparam [31:0] KIND = g;
      reg [15:0] mem [0:255];
      reg [15:0] rd_q;
      // Write one kind of one channel; read port is registered
      always @(posedge clk)
      begin
        if (wr_en && (wr_kind == KIND[1:0]))
          mem[wr_addr] <= wr_data;
        rd_q <= mem[rd_addr];
      end
      assign rd_data[16*g +: 16] = rd_q;
    end
  endgenerate

endmodule // scs_corr_store

`default_nettype wire

// >>> design/scs_path_latch.v
`timescale 1ns/1ns
`default_nettype none

// Trigger qualification and scanner channel-code capture
module scs_path_latch (
  input wire clk,
  input wire rst_n,
  input wire multi_en,
  input wire ext_mode,
  input wire sw_trig,
  input wire external_trigger_in,
  input wire [7:0] path_code_n,
  input wire path_latch_enable_n,
  output reg trig_q,
  output reg load_q,
  output reg [7:0] code_q
);

  reg trig_prev_q;
  wire ext_rise;
  wire trig_d;

  // Rising edge only; a held-high trigger pin fires once
  assign ext_rise = external_trigger_in & ~trig_prev_q;
  // External pin counts in external mode whatever the multi setting
  assign trig_d = ext_mode ? ext_rise : sw_trig;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_prev_q <= 1'b0;
      trig_q <= 1'b0;
      load_q <= 1'b0;
      code_q <= 8'h00;
    end
    else
    begin
      trig_prev_q <= external_trigger_in;
      trig_q <= trig_d;
      // Code pins are captured on every trigger, but only loaded when multi is on and latch enable is low
      load_q <= trig_d & multi_en & ~path_latch_enable_n;
      if (trig_d)
        code_q <= ~path_code_n;
    end
  end

endmodule // scs_path_latch

`default_nettype wire

// >>> design/scs_regs.vh
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

// Register byte offsets on the Avalon-MM slave
`define SCS_OFF_CTRL 6'h00
`define SCS_OFF_CHAN 6'h04
`define SCS_OFF_STEP 6'h08
`define SCS_OFF_STAT 6'h0C
`define SCS_OFF_MEAS 6'h10
`define SCS_OFF_LREF 6'h14
`define SCS_OFF_CORR_OS 6'h18
`define SCS_OFF_CORR_LR 6'h1C
`define SCS_OFF_TRIG 6'h20

// Control register fields and reset value
`define SCS_CTRL_MULTI 0
`define SCS_CTRL_EXT 1
`define SCS_CTRL_COMMON 2
`define SCS_CTRL_RESET 3'h0

// Step register bits, one per panel control
`define SCS_STEP_UP_TEN 0
`define SCS_STEP_UP_ONE 1
`define SCS_STEP_DN_ONE 2
`define SCS_STEP_DN_TEN 3
`define SCS_STEP_BIG 8'h0A
`define SCS_STEP_SMALL 8'h01

// Measured-data register layout and data-set kinds
`define SCS_MEAS_KIND_HI 17
`define SCS_MEAS_KIND_LO 16
`define SCS_KIND_OPEN 2'h0
`define SCS_KIND_SHORT 2'h1
`define SCS_KIND_LOAD 2'h2
`define SCS_KIND_REF 2'h3

// Status register fields
`define SCS_STAT_CHAN_LO 0
`define SCS_STAT_ANALOG 8
`define SCS_STAT_CYCLE 9
`define SCS_STAT_SWEEP 10
`define SCS_STAT_MULTI 11

// Channel storage
`define SCS_LAST_CH 8'hFF
`define SCS_CHAN_RESET 8'h00

`endif

// >>> design/scs_top.v
// Behaviour
// - Multi off: ignore channel code and latch enable
// - Multi off: both done outputs held low
// - External trigger accepted in external mode always
// - Code pins inverted binary, bit 7 MSB
// - Trigger loads code only with latch enable low
// - Local selection immediate, scanner selection on trigger
// - 256 correction sets, indexed by active channel
// - Correction data kept through reset, never initialised
// - Load reference to all channels or active one
// - Measured data stored in active channel slot; code stores it only while multi is on
// - Step controls: up/down by ten or one
// - Multi on: apply active channel's correction data
// - External trigger taken on rising edge
// - Analog-done output low when analog part ends
// - Cycle-done output low when cycle completes
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "scs_regs.vh"

module scs_top (
  input wire clk,
  input wire rst_n,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire external_trigger_in,
  input wire [7:0] path_code_n,
  input wire path_latch_enable_n,
  input wire analog_end_evt,
  input wire cycle_end_evt,
  output reg analog_done_n,
  output reg cycle_done_n,
  output reg meas_start_q,
  output reg [7:0] active_chan_q,
  output reg corr_apply_q,
  output reg [15:0] corr_open_q,
  output reg [15:0] corr_short_q,
  output reg [15:0] corr_load_q,
  output reg [15:0] corr_ref_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg [2:0] ctrl_q;
  reg sw_trig_q;
  reg sweep_q;
  reg [7:0] sweep_idx_q;
  reg [15:0] lref_q;
  reg mw_en_q;
  reg [7:0] mw_addr_q;
  reg [1:0] mw_kind_q;
  reg [15:0] mw_data_q;
  reg [7:0] chan_d;
  reg [31:0] rdata_d;
  wire multi_en;
  wire ext_mode;
  wire common_ref;
  wire req;
  wire ack;
  wire wr_ack;
  wire [31:0] wdata;
  wire trig;
  wire pin_load;
  wire [7:0] pin_code;
  wire st_wr_en;
  wire [7:0] st_wr_addr;
  wire [1:0] st_wr_kind;
  wire [15:0] st_wr_data;
  wire [63:0] st_rd_data;

  assign multi_en = ctrl_q[`SCS_CTRL_MULTI];
  assign ext_mode = ctrl_q[`SCS_CTRL_EXT];
  assign common_ref = ctrl_q[`SCS_CTRL_COMMON];

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake

  // A request is answered one cycle after it appears; a load-reference
  // sweep holds waitrequest high so the store has a single writer
  assign req = avs_read | avs_write;
  assign ack = req & avs_waitrequest & ~sweep_q;
  assign wr_ack = ack & avs_write;

  // Lanes that are not enabled contribute zeros to the written value
  assign wdata = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      // Low for exactly one cycle per accepted request
      avs_waitrequest <= ~ack;
      if (ack && avs_read)
        avs_readdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux

  // Unmapped offsets read as zero
  always @*
  begin
    rdata_d = 32'h00000000;
    case (avs_address)
      `SCS_OFF_CTRL:
        rdata_d[2:0] = ctrl_q;
      `SCS_OFF_CHAN:
        rdata_d[7:0] = active_chan_q;
      `SCS_OFF_STAT:
      begin
        rdata_d[`SCS_STAT_CHAN_LO +: 8] = active_chan_q;
        rdata_d[`SCS_STAT_ANALOG] = analog_done_n;
        rdata_d[`SCS_STAT_CYCLE] = cycle_done_n;
        rdata_d[`SCS_STAT_SWEEP] = sweep_q;
        rdata_d[`SCS_STAT_MULTI] = multi_en;
      end
      `SCS_OFF_LREF:
        rdata_d[15:0] = lref_q;
      `SCS_OFF_CORR_OS:
        rdata_d = {corr_short_q, corr_open_q};
      `SCS_OFF_CORR_LR:
        rdata_d = {corr_ref_q, corr_load_q};
      default:
        rdata_d = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and software trigger

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `SCS_CTRL_RESET;
      sw_trig_q <= 1'b0;
    end
    else
    begin
      if (wr_ack && (avs_address == `SCS_OFF_CTRL))
        ctrl_q <= wdata[2:0];
      // One-cycle pulse; only used while trigger mode is internal
      sw_trig_q <= wr_ack && (avs_address == `SCS_OFF_TRIG) && wdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger and scanner channel code

  scs_path_latch u_latch (
    .clk(clk),
    .rst_n(rst_n),
    .multi_en(multi_en),
    .ext_mode(ext_mode),
    .sw_trig(sw_trig_q),
    .external_trigger_in(external_trigger_in),
    .path_code_n(path_code_n),
    .path_latch_enable_n(path_latch_enable_n),
    .trig_q(trig),
    .load_q(pin_load),
    .code_q(pin_code)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Active channel

  // Local selection (direct write or step) applies at once; scanner code
  // applies only on its qualified trigger. Local selection wins a tie.
  always @*
  begin
    chan_d = active_chan_q;
    if (wr_ack && (avs_address == `SCS_OFF_CHAN))
      chan_d = wdata[7:0];
    else if (wr_ack && (avs_address == `SCS_OFF_STEP))
    begin
      // Steps wrap modulo 256
      if (wdata[`SCS_STEP_UP_TEN])
        chan_d = active_chan_q + `SCS_STEP_BIG;
      else if (wdata[`SCS_STEP_UP_ONE])
        chan_d = active_chan_q + `SCS_STEP_SMALL;
      else if (wdata[`SCS_STEP_DN_ONE])
        chan_d = active_chan_q - `SCS_STEP_SMALL;
      else if (wdata[`SCS_STEP_DN_TEN])
        chan_d = active_chan_q - `SCS_STEP_BIG;
    end
    else if (pin_load)
      chan_d = pin_code;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      active_chan_q <= `SCS_CHAN_RESET;
    else
      active_chan_q <= chan_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Correction-store writes

  // Measured open/short/load data lands in the active channel's slot,
  // and only while multi is on
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mw_en_q <= 1'b0;
      mw_addr_q <= 8'h00;
      mw_kind_q <= `SCS_KIND_OPEN;
      mw_data_q <= 16'h0000;
    end
    else
    begin
      mw_en_q <= 1'b0;
      if (wr_ack && (avs_address == `SCS_OFF_MEAS) && multi_en)
      begin
        mw_en_q <= 1'b1;
        mw_addr_q <= active_chan_q;
        mw_kind_q <= wdata[`SCS_MEAS_KIND_HI:`SCS_MEAS_KIND_LO];
        mw_data_q <= wdata[15:0];
      end
      else if (wr_ack && (avs_address == `SCS_OFF_LREF) && !common_ref)
      begin
        mw_en_q <= 1'b1;
        mw_addr_q <= active_chan_q;
        mw_kind_q <= `SCS_KIND_REF;
        mw_data_q <= wdata[15:0];
      end
    end
  end

  // A common reference is swept into all channels, one per cycle;
  // the bus stalls for the 256 cycles instead of needing a wider store
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sweep_q <= 1'b0;
      sweep_idx_q <= 8'h00;
      lref_q <= 16'h0000;
    end
    else
    begin
      if (wr_ack && (avs_address == `SCS_OFF_LREF))
      begin
        lref_q <= wdata[15:0];
        sweep_q <= common_ref;
        sweep_idx_q <= 8'h00;
      end
      else if (sweep_q)
      begin
        sweep_idx_q <= sweep_idx_q + 8'h01;
        if (sweep_idx_q == `SCS_LAST_CH)
          sweep_q <= 1'b0;
      end
    end
  end

  assign st_wr_en = sweep_q | mw_en_q;
  assign st_wr_addr = sweep_q ? sweep_idx_q : mw_addr_q;
  assign st_wr_kind = sweep_q ? `SCS_KIND_REF : mw_kind_q;
  assign st_wr_data = sweep_q ? lref_q : mw_data_q;

  // Store has no reset input at all, so nothing here can initialise it
  scs_corr_store u_store (
    .clk(clk),
    .wr_en(st_wr_en),
    .wr_addr(st_wr_addr),
    .wr_kind(st_wr_kind),
    .wr_data(st_wr_data),
    .rd_addr(active_chan_q),
    .rd_data(st_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Correction data to the measurement path

  // Data follows the active channel two cycles after it changes
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      corr_apply_q <= 1'b0;
      corr_open_q <= 16'h0000;
      corr_short_q <= 16'h0000;
      corr_load_q <= 16'h0000;
      corr_ref_q <= 16'h0000;
    end
    else
    begin
      corr_apply_q <= multi_en;
      corr_open_q <= st_rd_data[15:0];
      corr_short_q <= st_rd_data[31:16];
      corr_load_q <= st_rd_data[47:32];
      corr_ref_q <= st_rd_data[63:48];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Measurement start and done outputs

  // With multi on, done lines go high when a measurement starts and low on its end
  // events; an end event in the same cycle as a start wins
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meas_start_q <= 1'b0;
      analog_done_n <= 1'b0;
      cycle_done_n <= 1'b0;
    end
    else
    begin
      meas_start_q <= trig;
      if (!multi_en)
      begin
        analog_done_n <= 1'b0;
        cycle_done_n <= 1'b0;
      end
      else
      begin
        if (analog_end_evt)
          analog_done_n <= 1'b0;
        else if (trig)
          analog_done_n <= 1'b1;
        if (cycle_end_evt)
          cycle_done_n <= 1'b0;
        else if (trig)
          cycle_done_n <= 1'b1;
      end
    end
  end

endmodule // scs_top

`default_nettype wire

// >>> sim/scanner_channel_select_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "scs_regs.vh"
module scanner_channel_select_tb;
  logic clk, rst_n, avs_read, avs_write, analog_end_evt, cycle_end_evt;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, rdq;
  logic [3:0] avs_byteenable;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, external_trigger_in, path_latch_enable_n;
  wire analog_done_n, cycle_done_n, meas_start_q, corr_apply_q;
  wire [7:0] path_code_n, active_chan_q;
  wire [15:0] corr_open_q, corr_short_q, corr_load_q, corr_ref_q;
  int n_mismatch, total_checks, n_start, cycles, s;
  scs_top u_scs_top (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_trigger_in(external_trigger_in), .path_code_n(path_code_n),
    .path_latch_enable_n(path_latch_enable_n), .analog_end_evt(analog_end_evt),
    .cycle_end_evt(cycle_end_evt), .analog_done_n(analog_done_n), .cycle_done_n(cycle_done_n),
    .meas_start_q(meas_start_q), .active_chan_q(active_chan_q), .corr_apply_q(corr_apply_q),
    .corr_open_q(corr_open_q), .corr_short_q(corr_short_q), .corr_load_q(corr_load_q),
    .corr_ref_q(corr_ref_q));
  scs_scanner_model u_scs_scanner_model (.clk(clk), .external_trigger_in(external_trigger_in),
    .path_code_n(path_code_n), .path_latch_enable_n(path_latch_enable_n));
  ////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Start counter and hang guard; runs take several hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (meas_start_q === 1'b1)
      n_start++;
    if (cycles == 10000)
    begin
      n_mismatch++;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon word; held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input string what, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rdq);
  endtask
  task trig;
    s = n_start;
    u_scs_scanner_model.fire();
    repeat (6) @(posedge clk);
  endtask
  // One end event, then time for the done line to settle
  task pulse(input logic a);
    @(posedge clk);
    analog_end_evt <= a;
    cycle_end_evt <= !a;
    @(posedge clk);
    analog_end_evt <= 1'b0;
    cycle_end_evt <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Open, short and load data for one channel
  task meas3(input logic [7:0] ch, input logic [31:0] base);
    wr(`SCS_OFF_CHAN, {24'h0, ch});
    for (int k = 0; k < 3; k++)
      wr(`SCS_OFF_MEAS, (k << 16) + base + k);
  endtask
  task do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////
  task t_local;
    logic [7:0] ch;
    ch = 8'hFB;
    wr(`SCS_OFF_CHAN, 32'hFB);
    check("chan pin", 32'hFB, {24'h0, active_chan_q});
    for (int k = 0; k < 4; k++)
    begin
      wr(`SCS_OFF_STEP, 32'h1 << k);
      ch = ch + (k == 0 ? `SCS_STEP_BIG : k == 1 ? `SCS_STEP_SMALL : k == 2 ? 8'hFF : 8'hF6);
      check("step", {24'h0, ch}, {24'h0, active_chan_q});
    end
    rdc("unmapped", 6'h3C, 32'h0);
    $display("test local done");
  endtask
  task t_scan;
    wr(`SCS_OFF_CTRL, 32'h3);
    u_scs_scanner_model.present(8'hA5, 1'b1);
    repeat (4) @(posedge clk);
    check("before trigger", 32'hFB, {24'h0, active_chan_q});
    trig;
    check("start", 32'(s + 1), 32'(n_start));
    check("scan chan", 32'hA5, {24'h0, active_chan_q});
    check("apply", 32'h1, {31'h0, corr_apply_q});
    pulse(1'b1);
    check("analog done", 32'h1, {30'h0, analog_done_n, cycle_done_n});
    pulse(1'b0);
    check("cycle done", 32'h0, {30'h0, analog_done_n, cycle_done_n});
    u_scs_scanner_model.present(8'h3C, 1'b0);
    trig;
    check("unqualified", 32'hA5, {24'h0, active_chan_q});
    $display("test scan done");
  endtask
  task t_off;
    wr(`SCS_OFF_CTRL, 32'h2);
    u_scs_scanner_model.present(8'h11, 1'b1);
    trig;
    check("start off", 32'(s + 1), 32'(n_start));
    check("ignored", 32'hA5, {24'h0, active_chan_q});
    check("done off", 32'h0, {30'h0, analog_done_n, cycle_done_n});
    $display("test off done");
  endtask
  task t_store;
    wr(`SCS_OFF_CTRL, 32'h1);
    meas3(8'h07, 32'h1110);
    meas3(8'h08, 32'h2220);
    wr(`SCS_OFF_CTRL, 32'h5);
    wr(`SCS_OFF_LREF, 32'h4321);
    wr(`SCS_OFF_CTRL, 32'h1);
    wr(`SCS_OFF_LREF, 32'h0F0F);
    // Store write, store read and pin stage lag the bus answer
    repeat (2) @(posedge clk);
    rdc("ch8 lr", `SCS_OFF_CORR_LR, 32'h0F0F2222);
    wr(`SCS_OFF_CHAN, 32'h07);
    rdc("ch7 os", `SCS_OFF_CORR_OS, 32'h11111110);
    rdc("ch7 lr", `SCS_OFF_CORR_LR, 32'h43211112);
    check("open pin", 32'h1110, {16'h0, corr_open_q});
    check("short pin", 32'h1111, {16'h0, corr_short_q});
    check("lr pins", 32'h43211112, {corr_ref_q, corr_load_q});
    $display("test store done");
  endtask
  // Internal mode: pin edges are not triggers, a software trigger is
  task t_soft;
    trig;
    check("pin in internal", 32'(s), 32'(n_start));
    wr(`SCS_OFF_TRIG, 32'h1);
    repeat (4) @(posedge clk);
    check("soft start", 32'(s + 1), 32'(n_start));
    rdc("status", `SCS_OFF_STAT, 32'h00000B11);
    $display("test soft done");
  endtask
  task t_keep;
    do_reset;
    rdc("ctrl", `SCS_OFF_CTRL, 32'h0);
    rdc("chan", `SCS_OFF_CHAN, 32'h0);
    wr(`SCS_OFF_CHAN, 32'h07);
    // Multi is off after reset, so this measured value must be dropped
    wr(`SCS_OFF_MEAS, 32'h0000BEEF);
    rdc("kept os", `SCS_OFF_CORR_OS, 32'h11111110);
    rdc("kept lr", `SCS_OFF_CORR_LR, 32'h43211112);
    $display("test keep done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst_n, avs_read, avs_write, analog_end_evt, cycle_end_evt} = 5'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    {n_mismatch, total_checks, n_start, cycles} = 128'h0;
    do_reset;
    t_local;
    t_scan;
    t_off;
    t_store;
    t_soft;
    t_keep;
    conclude;
  end
endmodule // scanner_channel_select_tb
`default_nettype wire

// >>> sim/scs_checker_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "scs_regs.vh"
module scs_checker (
  input wire clk,
  input wire rst_n,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  input wire external_trigger_in,
  input wire [7:0] path_code_n,
  input wire path_latch_enable_n,
  input wire analog_end_evt,
  input wire cycle_end_evt,
  input wire analog_done_n,
  input wire cycle_done_n,
  input wire meas_start_q,
  input wire [7:0] active_chan_q,
  input wire corr_apply_q
);
  logic ext_q;
  // Mode shadow lags one cycle, so triggers right after a mode write are not judged
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ext_q <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == `SCS_OFF_CTRL && avs_byteenable[0])
      ext_q <= avs_writedata[`SCS_CTRL_EXT];
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  off_done_low_a: assert property (!corr_apply_q |=> !analog_done_n && !cycle_done_n)
    else $error("done line high with correction off");
  // Edge is registered twice inside (trig_q, then meas_start_q), so the start pulse is seen two samples later
  trig_start_a: assert property (ext_q && $rose(external_trigger_in)
    |-> ##2 meas_start_q) else $error("external trigger not taken");
  code_load_a: assert property (ext_q && corr_apply_q && !path_latch_enable_n
    && $rose(external_trigger_in) |-> ##2 active_chan_q == ~$past(path_code_n, 2))
    else $error("scanner code not loaded");
  no_load_a: assert property (ext_q && $rose(external_trigger_in)
    && (!corr_apply_q || path_latch_enable_n) |=> $stable(active_chan_q) [*2])
    else $error("channel loaded without qualification");
  start_done_a: assert property (meas_start_q && corr_apply_q
    |=> analog_done_n && cycle_done_n) else $error("done lines not raised on start");
  analog_end_a: assert property (analog_end_evt && corr_apply_q |=> !analog_done_n)
    else $error("analog done not driven low");
  cycle_end_a: assert property (cycle_end_evt |=> !cycle_done_n)
    else $error("cycle done not driven low");
  // A scanner load lands in the same cycle as the start pulse
  chan_cause_a: assert property (!$stable(active_chan_q)
    |-> meas_start_q || $past(avs_write)) else $error("active channel changed without cause");
  ack_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:260] !avs_waitrequest) else $error("bus request never answered");
  ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
endmodule // scs_checker
bind scs_top scs_checker u_scs_checker (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .external_trigger_in(external_trigger_in), .path_code_n(path_code_n),
  .path_latch_enable_n(path_latch_enable_n), .analog_end_evt(analog_end_evt),
  .cycle_end_evt(cycle_end_evt), .analog_done_n(analog_done_n), .cycle_done_n(cycle_done_n),
  .meas_start_q(meas_start_q), .active_chan_q(active_chan_q), .corr_apply_q(corr_apply_q));
`default_nettype wire

// >>> sim/scs_scanner_model.sv
`timescale 1ns/1ns
`default_nettype none
module scs_scanner_model (
  input wire logic clk,
  output var logic external_trigger_in,
  output var logic [7:0] path_code_n,
  output var logic path_latch_enable_n
);
  // Idle: trigger grounded, enable released
  initial
  begin
    external_trigger_in = 1'b0;
    path_code_n = 8'hFF;
    path_latch_enable_n = 1'b1;
  end
  // Enable up, code, enable down if qualified; code never moves while qualified
  task present(input logic [7:0] ch, input logic qualify);
    @(posedge clk);
    path_latch_enable_n <= 1'b1;
    @(posedge clk);
    path_code_n <= ~ch;
    @(posedge clk);
    path_latch_enable_n <= !qualify;
  endtask
  // Pulse of 25 cycles, one microsecond, issued only after the code is set
  task fire;
    repeat (2) @(posedge clk);
    external_trigger_in <= 1'b1;
    repeat (25) @(posedge clk);
    external_trigger_in <= 1'b0;
  endtask
endmodule // scs_scanner_model
`default_nettype wire
